// File: srbo_pkg.sv
/*
 * Shared constants, types and decode functions for the serial rate and bit order block:
 * register map, field positions, reset values and bit-rate divider figures.
 * Assumes a single 100 MHz system clock and a synchronous active-low reset in every user.
 */
package srbo_pkg;

    // ****************************************************************
    // register map, byte addresses on a six-bit address port
    // ****************************************************************
    localparam logic [5:0] CH_STRIDE = 6'h10;
    localparam logic [3:0] OFS_DIVISOR = 4'h0;
    localparam logic [3:0] OFS_MODE = 4'h1;
    localparam logic [3:0] OFS_FORMAT = 4'h2;
    localparam logic [3:0] OFS_TX_HOLD = 4'h3;
    localparam logic [3:0] OFS_RX_HOLD = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    localparam logic [5:0] ADDR_HALT_CTRL = 6'h20;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int FMT_ORDER_BIT = 3;
    localparam int FMT_INVERT_BIT = 2;
    localparam int FMT_CARD_BIT = 0;
    localparam logic [7:0] FMT_RESET = 8'hf2;
    localparam logic [7:0] FMT_FIXED_ONES = 8'hf2;
    localparam logic [15:0] HALT_RESET = 16'h3fff;
    localparam int HALT_CH0_BIT = 5;
    localparam int HALT_CH1_BIT = 6;
    localparam logic [7:0] DIVISOR_RESET = 8'hff;

    // ****************************************************************
    // bit-rate divider figures
    // ****************************************************************
    localparam logic [4:0] ASYNC_BIT_BASE_LAST = 5'h1f;
    localparam logic [1:0] SYNC_BIT_BASE_LAST = 2'h3;
    localparam logic [3:0] EXT_OVERSAMPLE_LAST = 4'hf;
    localparam int NUM_CH = 2;

    // channel mode: prescale, clocked synchronous, external clock, seven-bit characters
    typedef struct packed {
        logic seven_bit;
        logic ext_clk;
        logic sync_mode;
        logic [1:0] prescale;
    } srbo_mode_t;

    localparam srbo_mode_t MODE_RESET = 5'h00;

    // prescaler mask: all-ones in the low bits marks one prescaled clock
    function automatic logic [5:0] prescale_mask(input logic [1:0] sel);
        unique case (sel)
            2'b00: prescale_mask = 6'h00;
            2'b01: prescale_mask = 6'h03;
            2'b10: prescale_mask = 6'h0f;
            2'b11: prescale_mask = 6'h3f;
        endcase
    endfunction

endpackage

// File: srbo_rate_gen.sv
/*
 * One channel's bit-rate generator: prescaler, reloading divisor counter and
 * oversample counter, or an external clock edge counter.
 * Assumes ext_edge is already synchronised to clk and is one cycle long per edge.
 */
`timescale 1ns/1ps
module srbo_rate_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire srbo_pkg::srbo_mode_t mode,
    input wire logic [7:0] divisor,
    input wire logic ext_edge,
    // ticks
    output logic sample_tick,
    output logic bit_tick
);
    logic [5:0] pre_cnt_reg;
    logic [7:0] div_cnt_reg;
    logic [4:0] post_cnt_reg;
    logic [3:0] ext_cnt_reg;
    logic pre_tick;
    logic base_tick;

    assign pre_tick = (pre_cnt_reg & srbo_pkg::prescale_mask(mode.prescale))
        == srbo_pkg::prescale_mask(mode.prescale);
    assign base_tick = run && !mode.ext_clk && pre_tick && (div_cnt_reg == 8'h00);

    // ****************************************************************
    // prescaler and divisor counter
    // ****************************************************************
    // free-running prescaler, held clear while stopped so the first period is whole
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            pre_cnt_reg <= 6'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 6'h01;
        end
    end

    // divisor counter runs N..0, so a period is N+1 prescaled clocks
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            div_cnt_reg <= divisor;
        end else if (pre_tick) begin
            if (div_cnt_reg == 8'h00) begin
                div_cnt_reg <= divisor;
            end else begin
                div_cnt_reg <= div_cnt_reg - 8'h01;
            end
        end
    end

    // ****************************************************************
    // bit period counters
    // ****************************************************************
    // internal clock: 32 base ticks per async bit, 4 per synchronous bit
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            post_cnt_reg <= 5'h00;
        end else if (base_tick) begin
            post_cnt_reg <= post_cnt_reg + 5'h01;
        end
    end

    // external clock: sixteen edges per async bit
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            ext_cnt_reg <= 4'h0;
        end else if (mode.ext_clk && ext_edge) begin
            ext_cnt_reg <= ext_cnt_reg + 4'h1;
        end
    end

    // registered ticks
    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else if (mode.ext_clk) begin
            sample_tick <= ext_edge;
            if (mode.sync_mode) begin
                bit_tick <= ext_edge;
            end else begin
                bit_tick <= ext_edge && (ext_cnt_reg == srbo_pkg::EXT_OVERSAMPLE_LAST);
            end
        end else if (mode.sync_mode) begin
            sample_tick <= base_tick && (post_cnt_reg[1:0] == srbo_pkg::SYNC_BIT_BASE_LAST);
            bit_tick <= base_tick && (post_cnt_reg[1:0] == srbo_pkg::SYNC_BIT_BASE_LAST);
        end else begin
            sample_tick <= base_tick && post_cnt_reg[0];
            bit_tick <= base_tick && (post_cnt_reg == srbo_pkg::ASYNC_BIT_BASE_LAST);
        end
    end

endmodule

// File: srbo_top.sv
/*
 * Two-channel serial rate and bit order block: per-channel bit-rate generators,
 * format register with bit-order select, transmit and receive bit reordering,
 * and the shared module halt register with standby handling.
 * Assumes a register master on the same clock, one-cycle strobes, read data one
 * cycle after the read strobe. External serial clock pins are asynchronous.
 * Standby inputs and receive words come from logic on the same clock.
 */
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module srbo_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // register port
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // power state
    input wire logic HW_STANDBY,
    input wire logic SW_STANDBY,
    // external serial clocks, one pin per channel
    input wire logic [1:0] SCK_IN,
    // receive side, one word per channel as it arrived on the line
    input wire logic [1:0][7:0] RX_WORD,
    input wire logic [1:0] RX_LOAD,
    // transmit side, word in line order
    output logic [1:0][7:0] TX_WORD,
    output logic [1:0] TX_LOAD,
    // timing and state
    output logic [1:0] SAMPLE_TICK,
    output logic [1:0] BIT_TICK,
    output logic [1:0] CH_HALTED,
    output logic [1:0] MSB_FIRST,
    output logic [1:0] CARD_MODE,
    output logic [1:0] DATA_INVERT
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // swap bit order of a byte
    function automatic logic [7:0] reverse8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = d[7 - k];
        end
        reverse8 = r;
    endfunction

    // line order: reversed only when MSB-first and not async seven-bit
    function automatic logic [7:0] line_order(input logic [7:0] d, input logic msb,
                                              input srbo_pkg::srbo_mode_t m);
        if (msb && !(m.seven_bit && !m.sync_mode)) begin
            line_order = reverse8(d);
        end else begin
            line_order = d;
        end
    endfunction

    // ****************************************************************
    // shared state
    // ****************************************************************
    logic [15:0] halt_ctrl_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic hit_halt;
    logic [1:0] halt_bit;
    logic [1:0] ch_sel;
    logic [1:0][15:0] ch_rdata;

    assign hit_halt = (ADDR == srbo_pkg::ADDR_HALT_CTRL);
    assign halt_bit[0] = halt_ctrl_reg[srbo_pkg::HALT_CH0_BIT];
    assign halt_bit[1] = halt_ctrl_reg[srbo_pkg::HALT_CH1_BIT];

    // halt register: hardware standby reloads it, software standby leaves it alone
    always_ff @(posedge MCLK) begin
        if (!RSTN || HW_STANDBY) begin
            halt_ctrl_reg <= srbo_pkg::HALT_RESET;
        end else if (WR && hit_halt) begin
            halt_ctrl_reg <= WDATA;
        end
    end

    // ****************************************************************
    // per-channel logic
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < srbo_pkg::NUM_CH; ch++) begin : g_ch
            logic halted_reg;
            logic [7:0] divisor_reg;
            srbo_pkg::srbo_mode_t mode_reg;
            logic order_reg;
            logic invert_reg;
            logic card_reg;
            logic [7:0] tx_hold_reg;
            logic [7:0] rx_hold_reg;
            logic [7:0] bit_count_reg;
            logic [7:0] tx_word_reg;
            logic tx_load_reg;
            logic sck_meta_reg;
            logic sck_sync_reg;
            logic sck_prev_reg;
            logic sck_edge;
            logic standby;
            logic run;
            logic access;
            logic wr_ch;
            logic [3:0] ofs;
            logic [7:0] fmt_read;
            logic sample_tick;
            logic bit_tick;

            assign ch_sel[ch] = (ADDR[5:4] == 2'(ch));
            assign ofs = ADDR[3:0];
            assign standby = HW_STANDBY || SW_STANDBY;
            assign run = !halted_reg && !standby;
            // a halted channel neither takes writes nor returns data
            assign access = ch_sel[ch] && !halted_reg;
            assign wr_ch = WR && access;
            assign sck_edge = sck_sync_reg && !sck_prev_reg;
            assign fmt_read = srbo_pkg::FMT_FIXED_ONES
                | ({7'h00, order_reg} << srbo_pkg::FMT_ORDER_BIT)
                | ({7'h00, invert_reg} << srbo_pkg::FMT_INVERT_BIT)
                | ({7'h00, card_reg} << srbo_pkg::FMT_CARD_BIT);

            // stop lands one cycle after the writing bus cycle has finished
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    halted_reg <= 1'b1;
                end else begin
                    halted_reg <= halt_bit[ch];
                end
            end

            // divisor and mode survive standby; only reset reloads them
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    divisor_reg <= srbo_pkg::DIVISOR_RESET;
                    mode_reg <= srbo_pkg::MODE_RESET;
                end else if (wr_ch && ofs == srbo_pkg::OFS_DIVISOR) begin
                    divisor_reg <= WDATA[7:0];
                end else if (wr_ch && ofs == srbo_pkg::OFS_MODE) begin
                    mode_reg <= WDATA[4:0];
                end
            end

            // format register: reserved bits are not stored and read as one
            always_ff @(posedge MCLK) begin
                if (!RSTN || standby || halted_reg) begin
                    order_reg <= srbo_pkg::FMT_RESET[srbo_pkg::FMT_ORDER_BIT];
                    invert_reg <= srbo_pkg::FMT_RESET[srbo_pkg::FMT_INVERT_BIT];
                    card_reg <= srbo_pkg::FMT_RESET[srbo_pkg::FMT_CARD_BIT];
                end else if (wr_ch && ofs == srbo_pkg::OFS_FORMAT) begin
                    order_reg <= WDATA[srbo_pkg::FMT_ORDER_BIT];
                    invert_reg <= WDATA[srbo_pkg::FMT_INVERT_BIT];
                    card_reg <= WDATA[srbo_pkg::FMT_CARD_BIT];
                end
            end

            // transmit holding: stored as written, sent in line order
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    tx_hold_reg <= 8'h00;
                    tx_word_reg <= 8'h00;
                    tx_load_reg <= 1'b0;
                end else begin
                    tx_load_reg <= wr_ch && ofs == srbo_pkg::OFS_TX_HOLD;
                    if (wr_ch && ofs == srbo_pkg::OFS_TX_HOLD) begin
                        tx_hold_reg <= WDATA[7:0];
                        tx_word_reg <= line_order(WDATA[7:0], order_reg, mode_reg);
                    end
                end
            end

            // receive holding: line order turned back to value order
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    rx_hold_reg <= 8'h00;
                end else if (RX_LOAD[ch] && run) begin
                    rx_hold_reg <= line_order(RX_WORD[ch], order_reg, mode_reg);
                end
            end

            // external clock pin passes two flip-flops before the edge detector
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    sck_meta_reg <= 1'b0;
                    sck_sync_reg <= 1'b0;
                    sck_prev_reg <= 1'b0;
                end else begin
                    sck_meta_reg <= SCK_IN[ch];
                    sck_sync_reg <= sck_meta_reg;
                    sck_prev_reg <= sck_sync_reg;
                end
            end

            // bit counter gives software a view of the generator running
            always_ff @(posedge MCLK) begin
                if (!RSTN) begin
                    bit_count_reg <= 8'h00;
                end else if (bit_tick) begin
                    bit_count_reg <= bit_count_reg + 8'h01;
                end
            end

            srbo_rate_gen u_rate (
                .clk(MCLK),
                .rst_n(RSTN),
                .run(run),
                .mode(mode_reg),
                .divisor(divisor_reg),
                .ext_edge(sck_edge),
                .sample_tick(sample_tick),
                .bit_tick(bit_tick)
            );

            // read mux; a halted channel reads as zero
            always_comb begin
                ch_rdata[ch] = 16'h0000;
                if (access) begin
                    unique case (ofs)
                        srbo_pkg::OFS_DIVISOR: ch_rdata[ch] = {8'h00, divisor_reg};
                        srbo_pkg::OFS_MODE: ch_rdata[ch] = {11'h000, mode_reg};
                        srbo_pkg::OFS_FORMAT: ch_rdata[ch] = {8'h00, fmt_read};
                        srbo_pkg::OFS_TX_HOLD: ch_rdata[ch] = {8'h00, tx_hold_reg};
                        srbo_pkg::OFS_RX_HOLD: ch_rdata[ch] = {8'h00, rx_hold_reg};
                        srbo_pkg::OFS_STATUS: ch_rdata[ch] = {8'h00, bit_count_reg};
                        default: ch_rdata[ch] = 16'h0000;
                    endcase
                end
            end

            // outputs, each straight from a flip-flop
            assign TX_WORD[ch] = tx_word_reg;
            assign TX_LOAD[ch] = tx_load_reg;
            assign SAMPLE_TICK[ch] = sample_tick;
            assign BIT_TICK[ch] = bit_tick;
            assign CH_HALTED[ch] = halted_reg;
            assign MSB_FIRST[ch] = order_reg;
            assign CARD_MODE[ch] = card_reg;
            assign DATA_INVERT[ch] = invert_reg;
        end
    endgenerate

    // ****************************************************************
    // read data path
    // ****************************************************************
    // unmapped addresses answer zero
    always_comb begin
        rdata_next = 16'h0000;
        if (RD) begin
            if (hit_halt) begin
                rdata_next = halt_ctrl_reg;
            end else begin
                for (int c = 0; c < srbo_pkg::NUM_CH; c++) begin
                    if (ch_sel[c]) begin
                        rdata_next = ch_rdata[c];
                    end
                end
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;

endmodule

// File: srbo_remote_model.sv
/*
 * Remote serial party: external serial clock pins and received words.
 * Assumes clk is the 100 MHz system clock of the block under test.
 */
`timescale 1ns/1ps
module srbo_remote_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic [1:0] sck_en,
    input wire logic [1:0] rx_go,
    input wire logic [7:0] rx_byte,
    // pins toward the block
    output logic [1:0] sck,
    output logic [1:0][7:0] rx_word,
    output logic [1:0] rx_load
);
    // ************************************************
    // serial clock and receive words
    // ************************************************
    logic [1:0] div_cnt = 2'h0;
    initial begin
        sck = 2'b00;
        rx_word = '0;
        rx_load = 2'b00;
    end
    // period of eight system clocks, slower than a quarter and a sixth
    always @(posedge clk) begin
        div_cnt <= div_cnt + 2'h1;
        for (int i = 0; i < 2; i++) begin
            if (!sck_en[i]) begin
                sck[i] <= 1'b0; // still outside use
            end else if (div_cnt == 2'h3) begin
                sck[i] <= ~sck[i];
            end
        end
    end
    // idle word lines flip every cycle so a stale value never matches
    always @(posedge clk) begin
        rx_load <= rx_go;
        for (int i = 0; i < 2; i++) begin
            rx_word[i] <= rx_go[i] ? rx_byte : ~rx_word[i];
        end
    end
endmodule

// File: srbo_top_assertions.sv
/*
 * Checker for the top module ports, attached by the bind at the foot.
 * Assumes the one-clock register port and halt latency of the hand-over.
 */
`timescale 1ns/1ps
module srbo_top_assertions (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // register port
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    // power and state
    input wire logic HW_STANDBY,
    input wire logic SW_STANDBY,
    input wire logic [1:0] TX_LOAD,
    input wire logic [1:0] BIT_TICK,
    input wire logic [1:0] CH_HALTED,
    input wire logic [1:0] MSB_FIRST,
    input wire logic [1:0] CARD_MODE
);
    // ************************************************
    // properties
    // ************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    fmt_fixed_ones_a: assert property ($past(RD) &&
        $past(ADDR) inside {6'h02, 6'h12} && !$past(CH_HALTED[ADDR[4]])
        |-> RDATA[7:4] == 4'hf && RDATA[1]) else $error("format fixed one lost");
    halted_read_a: assert property ($past(RD) && !$past(ADDR[5]) &&
        $past(CH_HALTED[ADDR[4]]) |-> RDATA == 16'h0000) else $error("halted read not zero");
    halt_map_a: assert property (WR && ADDR == 6'h20 && !HW_STANDBY ##1 !HW_STANDBY
        |=> CH_HALTED == $past(WDATA[6:5], 2)) else $error("halt bits misrouted");
    tx_taken_a: assert property (WR && ADDR == 6'h03 && !CH_HALTED[0] &&
        !SW_STANDBY && !HW_STANDBY |=> TX_LOAD[0]) else $error("transmit write lost");
    tx_blocked_a: assert property (WR && ADDR == 6'h13 && CH_HALTED[1]
        |=> !TX_LOAD[1]) else $error("halted channel took a write");
    tick_gap_a: assert property (BIT_TICK[0] |=> !BIT_TICK[0] [*2])
        else $error("bit ticks too close");
    halted_quiet_a: assert property (CH_HALTED[1] && $past(CH_HALTED[1])
        |-> !BIT_TICK[1] && !MSB_FIRST[1] && !CARD_MODE[1]) else $error("halted channel active");
    hw_halt_a: assert property (HW_STANDBY [*2] |=> CH_HALTED == 2'b11)
        else $error("hardware standby kept channels");
    sw_keep_a: assert property (SW_STANDBY && !HW_STANDBY && !$past(HW_STANDBY) &&
        !WR && !$past(WR) |=> $stable(CH_HALTED)) else $error("software standby moved halt");
    sw_fmt_a: assert property (SW_STANDBY [*3] |-> MSB_FIRST == 2'b00 &&
        CARD_MODE == 2'b00) else $error("software standby kept format");
    cover property (WR && ADDR == 6'h20);
    cover property (TX_LOAD[0]);
    cover property (HW_STANDBY ##1 !HW_STANDBY);
endmodule
bind srbo_top srbo_top_assertions chk (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .HW_STANDBY(HW_STANDBY),
    .SW_STANDBY(SW_STANDBY), .TX_LOAD(TX_LOAD), .BIT_TICK(BIT_TICK),
    .CH_HALTED(CH_HALTED), .MSB_FIRST(MSB_FIRST), .CARD_MODE(CARD_MODE));

// File: test_serial_rate_and_bit_order.sv
/*
 * Self-checking bench: registers, bit rates, bit order, halt and standby.
 * Assumes the remote model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module test_serial_rate_and_bit_order;
    // ************************************************
    // signals and instances
    // ************************************************
    typedef struct packed {logic [5:0] a; logic [15:0] d; logic [15:0] e;} srbo_row_t;
    localparam srbo_row_t ROWS [6] = '{'{6'h02, 16'hffff, 16'h00ff},
        '{6'h02, 16'h0000, 16'h00f2}, '{6'h12, 16'h0001, 16'h00f3},
        '{6'h00, 16'h0000, 16'h0000}, '{6'h00, 16'h00ff, 16'h00ff},
        '{6'h01, 16'h001f, 16'h001f}};
    localparam logic [4:0] OM [4] = '{5'h00, 5'h00, 5'h10, 5'h14};
    localparam logic [7:0] OF [4] = '{8'h00, 8'h08, 8'h08, 8'h08};
    localparam logic [7:0] OT [4] = '{8'h13, 8'hc8, 8'h13, 8'hc8};
    logic mclk = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic hw_sb = 1'b0, sw_sb = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [1:0] sck_en = 2'b00, rx_go = 2'b00;
    logic [7:0] rx_byte = 8'h13;
    logic [1:0] sck_in, rx_load, tx_load, s_tick, bit_tick, halted, msb, card, inv;
    logic [1:0][7:0] rx_word, tx_word;
    int n_fail = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;
    srbo_top dut (.MCLK(mclk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
        .RD(rd_stb), .RDATA(rdata), .HW_STANDBY(hw_sb), .SW_STANDBY(sw_sb),
        .SCK_IN(sck_in), .RX_WORD(rx_word), .RX_LOAD(rx_load), .TX_WORD(tx_word),
        .TX_LOAD(tx_load), .SAMPLE_TICK(s_tick), .BIT_TICK(bit_tick),
        .CH_HALTED(halted), .MSB_FIRST(msb), .CARD_MODE(card), .DATA_INVERT(inv));
    srbo_remote_model model (.clk(mclk), .sck_en(sck_en), .rx_go(rx_go),
        .rx_byte(rx_byte), .sck(sck_in), .rx_word(rx_word), .rx_load(rx_load));
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // first gaps may carry the old settings, so only the third is judged
    task automatic rate(input logic [4:0] m, input logic [7:0] n, input int e);
        int c;
        int s;
        wr(6'h01, {11'h000, m});
        wr(6'h00, {8'h00, n});
        for (int k = 0; k < 3; k++) begin
            c = 0;
            s = 0;
            do begin
                @(posedge mclk);
                #1 c++;
                s += int'(s_tick[0]);
            end while (bit_tick[0] !== 1'b1 && c < 20000);
        end
        chk(16'(c), 16'(e));
        chk(16'(s), m[2] ? 16'h0001 : 16'h0010);
    endtask
    task automatic standby(input logic hw);
        @(posedge mclk);
        if (hw) hw_sb <= 1'b1;
        else sw_sb <= 1'b1;
        repeat (4) @(posedge mclk);
        hw_sb <= 1'b0;
        sw_sb <= 1'b0;
    endtask
    // ************************************************
    // main sequence and watchdog
    // ************************************************
    initial begin
        #800_000 n_fail++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        rd(6'h20, 16'h3fff);
        rd(6'h02, 16'h0000);
        wr(6'h20, 16'h0000);
        rd(6'h02, 16'h00f2);
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, ROWS[i].e);
        end
        $display("test registers done");
        rate(5'h00, 8'h00, 32);
        for (int n = 0; n < 4; n++) begin
            rate({3'b000, 2'(n)}, 8'h01, 64 << (2 * n));
        end
        rate(5'h04, 8'h00, 4);
        rate(5'h00, 8'hff, 8192);
        sck_en <= 2'b01;
        rate(5'h08, 8'h00, 128);
        rate(5'h0c, 8'h00, 8);
        sck_en <= 2'b00;
        $display("test rates done");
        foreach (OM[i]) begin
            wr(6'h01, {11'h000, OM[i]});
            wr(6'h02, {8'h00, OF[i]});
            wr(6'h03, 16'h0013);
            #1 chk({7'h00, tx_load[0], tx_word[0]}, {8'h01, OT[i]});
            @(posedge mclk);
            rx_go <= 2'b01;
            @(posedge mclk);
            rx_go <= 2'b00;
            rd(6'h04, {8'h00, OT[i]});
        end
        $display("test bit order done");
        wr(6'h20, 16'h0040);
        wr(6'h13, 16'h0055);
        wr(6'h02, 16'h000d);
        rd(6'h12, 16'h0000);
        rd(6'h02, 16'h00ff);
        chk({13'h0000, inv[0], card[0], msb[0]}, 16'h0007);
        wr(6'h20, 16'h0020);
        rd(6'h02, 16'h0000);
        chk({13'h0000, inv[0], card[0], msb[0]}, 16'h0000);
        rd(6'h12, 16'h00f2);
        wr(6'h20, 16'h0000);
        rd(6'h02, 16'h00f2);
        $display("test halt done");
        standby(1'b1);
        rd(6'h20, 16'h3fff);
        wr(6'h20, 16'h0000);
        wr(6'h02, 16'h0008);
        standby(1'b0);
        rd(6'h20, 16'h0000);
        rd(6'h02, 16'h00f2);
        $display("test standby done");
        end_sim();
    end
endmodule
